/* File: hw/tnmc_core.sv */
// message coordinator core: buffer pool, routing, slot timer and ahb-lite registers
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - power loss halts traffic, drops network driver
// RULE_02 - shutdown discards every held message
// RULE_03 - network side passes frames to framer
// RULE_04 - host messages checked: format, type, size, checksum
// RULE_05 - route address picks opposite host or network
// RULE_06 - every received message gets a reply
// RULE_07 - module number sets address, slot, priority
// RULE_08 - device number: prefix 0 top, 1 bottom
// RULE_09 - network messages wait for own slot
// RULE_10 - slot timer restarts: powerup, message end, noise
// RULE_11 - slot counts 0..99, wraps at 100
// RULE_12 - each slot lasts about 200 us
// RULE_13 - short option wraps slot count at 30
// RULE_14 - lower module numbers reach network first
// RULE_15 - never start while network message in progress
// RULE_16 - after sending, blocked until count wraps
// RULE_17 - wrap clears the blocked flag
// RULE_18 - network message stored, acknowledged before host send
// RULE_19 - host message stored, acknowledged before network send
// RULE_20 - store and forward converts port rates
// RULE_21 - sixteen shared buffers, freed once sent
// RULE_22 - arrival with pool full flags receive error
// RULE_23 - arrivals during power-up refused with error
// RULE_24 - network send tried up to four times
// RULE_25 - prescaler ticks slot timer, zero on restart
// RULE_26 - first-come allocation with free count tracking
module tnmc_core
	import tnmc_pkg::*;
#(
	parameter int SLOT_CYCLES = SLOT_CYCLES_DEF,
	parameter int BOOT_CYCLES = BOOT_CYCLES_DEF
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        power_loss_warning,
	input  wire logic [6:0]  module_number,
	input  wire logic [2:0]  rx_valid,
	input  wire tnmc_msg_t   rx_msg [3],
	output logic      [2:0]  rx_taken,
	output logic      [2:0]  rep_valid,
	output logic      [5:0]  rep_code,
	output logic      [1:0]  htx_valid,
	output tnmc_msg_t        htx_msg [2],
	input  wire logic [1:0]  htx_done,
	output logic             net_tx_start,
	output tnmc_msg_t        net_tx_msg,
	input  wire logic        net_tx_done,
	input  wire logic        net_tx_ok,
	input  wire logic        net_busy,
	input  wire logic        net_msg_end,
	input  wire logic        net_noise,
	output logic             net_drv_en,
	output logic             net_tx_err_led,
	output logic      [6:0]  slot_count
);
	initial begin
		if (SLOT_CYCLES < 2 || SLOT_CYCLES > 65535 || BOOT_CYCLES < 1 || BOOT_CYCLES > 65535)
			$error("tnmc_core: timing parameter out of range");
	end

	// destination of a checked message, PORT_BAD when unroutable
	function automatic logic [1:0] route_dst(input logic [7:0] r, input logic [6:0] m,
		input logic [1:0] src);
		logic [7:0] lo;
		logic [1:0] p;
		lo = (r >= DEV_PORT1) ? r - DEV_PORT1 : r;
		p  = (r >= DEV_PORT1) ? PORT_BOT : PORT_TOP; // RULE_08
		if (r >= DEV_LIMIT)
			return PORT_BAD;
		if (lo[6:0] == m) // RULE_07
			return (p == src) ? PORT_BAD : p;
		return (src == PORT_NET) ? PORT_BAD : PORT_NET; // RULE_05
	endfunction : route_dst

	// format, type, size and checksum check
	function automatic logic msg_ok(input tnmc_msg_t g);
		return g.fmt_ok && g.sum_ok && g.mtype <= MAX_TYPE && g.size != 8'h00
			&& g.size <= MAX_SIZE;
	endfunction : msg_ok

	tnmc_state_t st_q;
	logic [15:0] boot_q;
	logic [15:0] pre_q;
	logic [6:0]  slot_q;
	logic        blocked_q;
	logic        short_q;
	logic        rxerr_q;
	logic        txfail_q;
	logic        blink_q;
	logic [NUM_BUF-1:0] ent_v_q;
	logic [1:0]  ent_dst_q [NUM_BUF];
	logic [1:0]  ent_src_q [NUM_BUF];
	logic [2:0]  ent_try_q [NUM_BUF];
	tnmc_msg_t   ent_msg_q [NUM_BUF];
	logic [1:0]  htx_busy_q;
	logic [3:0]  htx_idx_q [2];
	logic        ntx_busy_q;
	logic [3:0]  ntx_idx_q;
	logic [1:0]  fail_pend_q;
	logic        aw_q;
	logic        awr_q;
	logic [7:0]  aadr_q;

	// combinational decisions
	logic        acc_fire;
	logic [1:0]  acc_src;
	tnmc_msg_t   acc_msg;
	logic [1:0]  acc_dst;
	logic        acc_store;
	logic [1:0]  acc_code;
	logic        any_free;
	logic [3:0]  free_idx;
	logic [4:0]  free_cnt;
	logic [6:0]  wrap_val;
	logic        tick;
	logic        wrap;
	logic        restart;
	logic        net_pend;
	logic [3:0]  net_idx;
	logic        slot_go;
	logic        ntx_fail;
	logic [1:0]  hpend;
	logic [3:0]  hidx [2];
	logic        ahb_go;

	assign wrap_val = short_q ? WRAP_SHORT : WRAP_LONG; // RULE_13
	assign tick     = (pre_q == 16'(SLOT_CYCLES - 1)); // RULE_12
	assign wrap     = tick && (slot_q == wrap_val - 7'h01); // RULE_11
	assign restart  = net_msg_end || net_noise; // RULE_10
	assign ntx_fail = ntx_busy_q && net_tx_done && !net_tx_ok;
	assign ahb_go   = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

	// pool scan: first free entry, free count, pending sends
	always_comb
	begin
		any_free = 1'b0;
		free_idx = 4'h0;
		free_cnt = 5'h00;
		net_pend = 1'b0;
		net_idx  = 4'h0;
		hpend    = 2'b00;
		hidx[0]  = 4'h0;
		hidx[1]  = 4'h0;
		for (int i = NUM_BUF - 1; i >= 0; i--)
		begin
			if (!ent_v_q[i])
			begin
				any_free = 1'b1; // RULE_26
				free_idx = 4'(i);
				free_cnt = free_cnt + 5'h01;
			end
			else if (ent_dst_q[i] == PORT_NET && !(ntx_busy_q && ntx_idx_q == 4'(i)))
			begin
				net_pend = 1'b1;
				net_idx  = 4'(i);
			end
			else if (ent_dst_q[i] != PORT_NET)
			begin
				hpend[ent_dst_q[i][0]] = 1'b1;
				hidx[ent_dst_q[i][0]]  = 4'(i);
			end
		end
	end

	// own slot, not blocked, line idle, at slot start
	assign slot_go = st_q == ST_RUN && net_pend && !ntx_busy_q && !blocked_q && !net_busy
		&& slot_q == module_number && pre_q == 16'h0000 && !restart; // RULE_09 RULE_14 RULE_15

	// one arrival per cycle: network first, then top, then bottom
	always_comb
	begin
		acc_fire = 1'b1;
		acc_src  = PORT_NET;
		if (rx_valid[2] && !rx_taken[2])
			acc_src = PORT_NET;
		else if (rx_valid[0] && !rx_taken[0])
			acc_src = PORT_TOP;
		else if (rx_valid[1] && !rx_taken[1])
			acc_src = PORT_BOT;
		else
			acc_fire = 1'b0;
		acc_fire  = acc_fire && st_q != ST_HALT;
		acc_msg   = rx_msg[acc_src];
		acc_dst   = route_dst(acc_msg.route, module_number, acc_src);
		acc_store = 1'b0;
		if (st_q == ST_BOOT)
			acc_code = REP_BUSY; // RULE_23
		else if (!msg_ok(acc_msg) || acc_dst == PORT_BAD)
			acc_code = REP_BAD; // RULE_04
		else if (!any_free)
			acc_code = REP_BUSY; // RULE_22
		else
		begin
			acc_code  = REP_OK;
			acc_store = 1'b1; // RULE_18 RULE_19 RULE_20
		end
	end

	// power-up, run and shutdown sequencing
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q   <= ST_BOOT;
			boot_q <= 16'h0000;
		end
		else if (power_loss_warning)
			st_q <= ST_HALT; // RULE_01
		else if (st_q == ST_BOOT)
		begin
			boot_q <= boot_q + 16'h0001;
			if (boot_q == 16'(BOOT_CYCLES - 1))
				st_q <= ST_RUN;
		end
	end

	// slot prescaler, slot counter and blocked flag
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_q     <= 16'h0000;
			slot_q    <= 7'h00;
			blocked_q <= 1'b0;
			blink_q   <= 1'b0;
		end
		else
		begin
			if (restart || st_q != ST_RUN || slot_q >= wrap_val)
			begin
				pre_q  <= 16'h0000; // RULE_25
				slot_q <= 7'h00; // RULE_10
			end
			else if (tick)
			begin
				pre_q  <= 16'h0000;
				slot_q <= wrap ? 7'h00 : slot_q + 7'h01; // RULE_11
			end
			else
				pre_q <= pre_q + 16'h0001;
			if (slot_go)
				blocked_q <= 1'b1; // RULE_16
			else if (wrap && !restart && st_q == ST_RUN)
				blocked_q <= 1'b0; // RULE_17
			if (wrap)
				blink_q <= ~blink_q;
		end
	end

	// shared buffer pool
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ent_v_q <= '0;
		else if (st_q == ST_HALT || power_loss_warning)
			ent_v_q <= '0; // RULE_02
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				if (htx_busy_q[p] && htx_done[p])
					ent_v_q[htx_idx_q[p]] <= 1'b0; // RULE_21
			end
			if (ntx_busy_q && net_tx_done && (net_tx_ok || ent_try_q[ntx_idx_q] == NET_TRIES))
				ent_v_q[ntx_idx_q] <= 1'b0; // RULE_24
			if (acc_fire && acc_store)
				ent_v_q[free_idx] <= 1'b1; // RULE_26
		end
	end

	// entry contents and retry counts
	always_ff @(posedge hclk)
	begin
		if (acc_fire && acc_store)
		begin
			ent_msg_q[free_idx] <= acc_msg;
			ent_dst_q[free_idx] <= acc_dst;
			ent_src_q[free_idx] <= acc_src;
			ent_try_q[free_idx] <= 3'h0;
		end
		if (slot_go)
			ent_try_q[net_idx] <= ent_try_q[net_idx] + 3'h1; // RULE_24
	end

	// host transmit ports, one message in flight each
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			htx_busy_q   <= 2'b00;
			htx_valid    <= 2'b00;
			htx_idx_q[0] <= 4'h0;
			htx_idx_q[1] <= 4'h0;
			htx_msg[0]   <= '0;
			htx_msg[1]   <= '0;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				if (st_q != ST_RUN || power_loss_warning)
				begin
					htx_busy_q[p] <= 1'b0; // RULE_01
					htx_valid[p]  <= 1'b0;
				end
				else if (htx_busy_q[p] && htx_done[p])
				begin
					htx_busy_q[p] <= 1'b0;
					htx_valid[p]  <= 1'b0;
				end
				else if (!htx_busy_q[p] && hpend[p])
				begin
					htx_busy_q[p] <= 1'b1; // RULE_18
					htx_valid[p]  <= 1'b1;
					htx_idx_q[p]  <= hidx[p];
					htx_msg[p]    <= ent_msg_q[hidx[p]];
				end
			end
		end
	end

	// network transmit: start pulse to framer, wait for outcome
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ntx_busy_q   <= 1'b0;
			ntx_idx_q    <= 4'h0;
			net_tx_start <= 1'b0;
			net_tx_msg   <= '0;
			net_drv_en   <= 1'b0;
		end
		else
		begin
			net_tx_start <= slot_go; // RULE_03 RULE_19
			net_drv_en   <= st_q == ST_RUN && !power_loss_warning; // RULE_01
			if (st_q != ST_RUN || power_loss_warning)
				ntx_busy_q <= 1'b0;
			else if (slot_go)
			begin
				ntx_busy_q <= 1'b1;
				ntx_idx_q  <= net_idx;
				net_tx_msg <= ent_msg_q[net_idx];
			end
			else if (ntx_busy_q && net_tx_done)
				ntx_busy_q <= 1'b0;
		end
	end

	// replies: acceptance reply first, retry failure waits its turn
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_taken    <= 3'b000;
			rep_valid   <= 3'b000;
			rep_code    <= 6'h00;
			fail_pend_q <= 2'b00;
		end
		else
		begin
			for (int p = 0; p < 3; p++)
			begin
				rx_taken[p]        <= acc_fire && acc_src == 2'(p);
				rep_valid[p]       <= 1'b0;
				rep_code[2*p +: 2] <= REP_OK;
				if (acc_fire && acc_src == 2'(p))
				begin
					rep_valid[p]       <= 1'b1; // RULE_06
					rep_code[2*p +: 2] <= acc_code;
				end
				else if (p < 2 && fail_pend_q[p % 2])
				begin
					rep_valid[p]       <= 1'b1;
					rep_code[2*p +: 2] <= REP_FAIL; // RULE_24
				end
			end
			for (int p = 0; p < 2; p++)
			begin
				if (st_q == ST_HALT)
					fail_pend_q[p] <= 1'b0;
				else if (ntx_fail && ent_try_q[ntx_idx_q] == NET_TRIES
					&& ent_src_q[ntx_idx_q] == 2'(p))
					fail_pend_q[p] <= 1'b1;
				else if (!(acc_fire && acc_src == 2'(p)))
					fail_pend_q[p] <= 1'b0;
			end
		end
	end

	// sticky error flags and flashing indicator; set beats clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rxerr_q        <= 1'b0;
			txfail_q       <= 1'b0;
			net_tx_err_led <= 1'b0;
		end
		else
		begin
			if (acc_fire && st_q == ST_RUN && msg_ok(acc_msg) && acc_dst != PORT_BAD && !any_free)
				rxerr_q <= 1'b1; // RULE_22
			else if (aw_q && awr_q && aadr_q == REG_STATUS && hwdata[STAT_RXERR])
				rxerr_q <= 1'b0;
			if (ntx_fail && ent_try_q[ntx_idx_q] == NET_TRIES)
				txfail_q <= 1'b1;
			else if (aw_q && awr_q && aadr_q == REG_STATUS && hwdata[STAT_TXFAIL])
				txfail_q <= 1'b0;
			net_tx_err_led <= (rxerr_q || txfail_q) && blink_q; // RULE_22
		end
	end

	// ahb-lite slave: zero wait, read data loaded in address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aw_q      <= 1'b0;
			awr_q     <= 1'b0;
			aadr_q    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			short_q   <= 1'b0;
		end
		else
		begin
			if (hready)
			begin
				aw_q   <= ahb_go;
				awr_q  <= hwrite;
				aadr_q <= haddr[7:0];
			end
			if (aw_q && awr_q && aadr_q == REG_CTRL)
				short_q <= hwdata[CTRL_SHORT]; // RULE_13
			hrdata <= 32'h0000_0000;
			if (ahb_go && !hwrite)
			begin
				unique case (haddr[7:0])
					REG_CTRL:   hrdata[CTRL_SHORT] <= short_q;
					REG_STATUS:
					begin
						hrdata[STAT_RXERR]           <= rxerr_q;
						hrdata[STAT_TXFAIL]          <= txfail_q;
						hrdata[STAT_BLOCKED]         <= blocked_q;
						hrdata[STAT_STATE +: 2]      <= st_q;
						hrdata[STAT_FREE +: 5]       <= free_cnt;
					end
					REG_SLOT:   hrdata[6:0] <= slot_q;
					default:    hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign slot_count = slot_q; // straight from the slot counter flop

	// checks
	AST_HALT_QUIET: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
		st_q == ST_HALT |=> !net_drv_en && !net_tx_start && htx_valid == 2'b00)
		else $error("traffic or driver active in shutdown");
	AST_HALT_EMPTY: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
		power_loss_warning |=> ##1 ent_v_q == '0)
		else $error("buffers survive shutdown");
	AST_TX_SLOT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
		net_tx_start |-> $past(slot_q) == module_number && $past(pre_q) == 16'h0000)
		else $error("network send outside own slot");
	AST_TX_IDLE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
		net_tx_start |-> !$past(net_busy))
		else $error("send started over busy network");
	AST_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
		net_tx_start |-> blocked_q)
		else $error("blocked flag not set after send");
	AST_UNBLOCK: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
		wrap && !slot_go && !restart && st_q == ST_RUN |=> !blocked_q)
		else $error("wrap did not clear blocked flag");
	AST_RESTART: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
		restart |=> slot_q == 7'h00 && pre_q == 16'h0000)
		else $error("slot timer not restarted");
	AST_SLOT_RANGE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
		slot_q < wrap_val || $changed(short_q))
		else $error("slot count past wrap value");
	AST_BOOT_BUSY: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_23
		acc_fire && st_q == ST_BOOT |=> rep_valid[$past(acc_src)]
		&& rep_code[2*$past(acc_src) +: 2] == REP_BUSY)
		else $error("power-up arrival not refused");
	AST_FULL_ERR: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_22
		acc_fire && st_q == ST_RUN && acc_code == REP_BUSY |=> rxerr_q)
		else $error("overflow not flagged");
	COV_SEND: cover property (@(posedge hclk) disable iff (!hresetn)
		net_tx_start ##[1:200] net_tx_done && net_tx_ok);
	COV_SHORT_WRAP: cover property (@(posedge hclk) disable iff (!hresetn) wrap && short_q);
	COV_FULL: cover property (@(posedge hclk) disable iff (!hresetn) rxerr_q && !$past(rxerr_q));
	COV_FAIL: cover property (@(posedge hclk) disable iff (!hresetn) txfail_q && !$past(txfail_q));
endmodule : tnmc_core

/* File: hw/tnmc_pkg.sv */
// shared constants and carrier types for the timeslot message coordinator
package tnmc_pkg;
	// clock and slot timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int SLOT_TIME_US    = 200;
	localparam int SLOT_CYCLES_DEF = (SLOT_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int BOOT_CYCLES_DEF = 1000;
	// slot counter wrap values and module number range
	localparam logic [6:0] WRAP_LONG  = 7'h64;
	localparam logic [6:0] WRAP_SHORT = 7'h1E;
	localparam logic [6:0] MOD_MAX    = 7'h63;
	localparam logic [7:0] DEV_PORT1  = 8'h64;
	localparam logic [7:0] DEV_LIMIT  = 8'hC8;
	// buffer pool, retry and message check limits
	localparam int         NUM_BUF    = 16;
	localparam logic [2:0] NET_TRIES  = 3'h4;
	localparam logic [3:0] MAX_TYPE   = 4'h9;
	localparam logic [7:0] MAX_SIZE   = 8'hF0;
	// register byte offsets and fields
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SLOT   = 8'h08;
	localparam int CTRL_SHORT    = 0;
	localparam int STAT_RXERR    = 0;
	localparam int STAT_TXFAIL   = 1;
	localparam int STAT_BLOCKED  = 2;
	localparam int STAT_STATE    = 4;
	localparam int STAT_FREE     = 8;
	// source and destination port codes
	localparam logic [1:0] PORT_TOP = 2'h0;
	localparam logic [1:0] PORT_BOT = 2'h1;
	localparam logic [1:0] PORT_NET = 2'h2;
	localparam logic [1:0] PORT_BAD = 2'h3;
	// reply codes
	localparam logic [1:0] REP_OK   = 2'h0;
	localparam logic [1:0] REP_BAD  = 2'h1;
	localparam logic [1:0] REP_BUSY = 2'h2;
	localparam logic [1:0] REP_FAIL = 2'h3;
	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [1:0] {
		ST_BOOT = 2'h0,
		ST_RUN  = 2'h1,
		ST_HALT = 2'h3
	} tnmc_state_t;

	// checked message descriptor, route is the destination device number
	typedef struct packed {
		logic       fmt_ok;
		logic       sum_ok;
		logic [3:0] mtype;
		logic [7:0] size;
		logic [7:0] route;
	} tnmc_msg_t;
endpackage : tnmc_pkg

/* File: test/tnmc_peer.sv */
// far-side model: host serial transmitters and the network peer
`timescale 1ns/1ps
module tnmc_peer
	import tnmc_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] htx_valid,
	input  wire logic       host_stall,
	input  wire logic       host_slow,
	output logic      [1:0] htx_done,
	input  wire logic       net_tx_start,
	input  wire logic       net_nak,
	output logic            net_tx_done,
	output logic            net_tx_ok,
	output logic            net_busy,
	output logic            net_msg_end
);
	logic [3:0] host_cnt_q [2];
	logic [3:0] net_cnt_q;

	// host ports finish a message promptly, slowly, or stall
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			htx_done   <= 2'h0;
			host_cnt_q <= '{4'h0, 4'h0};
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				htx_done[p] <= 1'b0;
				if (htx_valid[p] && !htx_done[p] && !host_stall)
				begin
					host_cnt_q[p] <= host_cnt_q[p] + 4'h1;
					if (host_cnt_q[p] >= (host_slow ? 4'h5 : 4'h0))
					begin
						htx_done[p]   <= 1'b1;
						host_cnt_q[p] <= 4'h0;
					end
				end
			end
		end
	end

	// peer frames one message at a time, then acks or naks it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			net_cnt_q   <= 4'h0;
			net_busy    <= 1'b0;
			net_tx_done <= 1'b0;
			net_tx_ok   <= 1'b0;
			net_msg_end <= 1'b0;
		end
		else
		begin
			net_tx_done <= 1'b0;
			net_msg_end <= 1'b0;
			net_tx_ok   <= ~net_tx_ok; // meaningless outside done
			if (net_tx_start)
			begin
				net_busy  <= 1'b1;
				net_cnt_q <= 4'hC;
			end
			else if (net_busy)
			begin
				net_cnt_q <= net_cnt_q - 4'h1;
				if (net_cnt_q == 4'h1)
				begin
					net_busy    <= 1'b0;
					net_tx_done <= 1'b1;
					net_tx_ok   <= !net_nak;
					net_msg_end <= 1'b1;
				end
			end
		end
	end
endmodule : tnmc_peer

/* File: test/tnmc_core_bench.sv */
// self-checking bench for the timeslot message coordinator core
`timescale 1ns/1ps
module tnmc_core_bench
	import tnmc_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic        power_loss_warning = 1'b0;
	logic [6:0]  module_number = 7'h07;
	logic [2:0]  rx_valid = 3'h0;
	tnmc_msg_t   rx_msg [3] = '{default: '0};
	logic        host_stall = 1'b0;
	logic        host_slow = 1'b0;
	logic        net_nak = 1'b0;
	logic        net_noise = 1'b0;
	logic        short_q = 1'b0;
	logic        busy_prev = 1'b0;
	logic [31:0] rnd = 32'h5E29A1C9;
	logic [7:0]  sz [4] = '{8'h00, 8'h01, MAX_SIZE, 8'hF1};
	int          mismatches = 0;
	int          comparisons = 0;
	int          starts = 0;
	int          cyc = 0;
	int          last_start = 0;
	logic [31:0] hrdata;
	logic [2:0]  rx_taken, rep_valid;
	logic [5:0]  rep_code;
	logic [1:0]  htx_valid, htx_done;
	tnmc_msg_t   htx_msg [2];
	tnmc_msg_t   net_tx_msg;
	logic [6:0]  slot_count;
	logic        hreadyout, hresp, net_tx_start, net_tx_done, net_tx_ok, net_busy;
	logic        net_msg_end, net_drv_en, net_tx_err_led;

	// 200 MHz clock
	always #2.5 hclk = ~hclk;

	tnmc_core #(.SLOT_CYCLES(8), .BOOT_CYCLES(4)) u_tnmc_core (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .power_loss_warning(power_loss_warning),
		.module_number(module_number), .rx_valid(rx_valid), .rx_msg(rx_msg),
		.rx_taken(rx_taken), .rep_valid(rep_valid), .rep_code(rep_code),
		.htx_valid(htx_valid), .htx_msg(htx_msg), .htx_done(htx_done),
		.net_tx_start(net_tx_start), .net_tx_msg(net_tx_msg), .net_tx_done(net_tx_done),
		.net_tx_ok(net_tx_ok), .net_busy(net_busy), .net_msg_end(net_msg_end),
		.net_noise(net_noise), .net_drv_en(net_drv_en), .net_tx_err_led(net_tx_err_led),
		.slot_count(slot_count)
	);

	tnmc_peer u_tnmc_peer (
		.hclk(hclk), .hresetn(hresetn), .htx_valid(htx_valid), .host_stall(host_stall),
		.host_slow(host_slow), .htx_done(htx_done), .net_tx_start(net_tx_start),
		.net_nak(net_nak), .net_tx_done(net_tx_done), .net_tx_ok(net_tx_ok),
		.net_busy(net_busy), .net_msg_end(net_msg_end)
	);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic conclude();
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic tnmc_msg_t good(input logic [7:0] r);
		return '{fmt_ok: 1'b1, sum_ok: 1'b1, mtype: 4'h1, size: 8'h10, route: r};
	endfunction : good

	// answered flag over reply code for a given source and message
	function automatic logic [2:0] exp_rep(input int s, input tnmc_msg_t m);
		if (!m.fmt_ok || !m.sum_ok || m.mtype > MAX_TYPE || m.size == 8'h0
			|| m.size > MAX_SIZE || m.route >= DEV_LIMIT)
			return {1'b1, REP_BAD};
		if (m.route % DEV_PORT1 == {1'b0, module_number})
			return {1'b1, ((m.route >= DEV_PORT1) == (s == 1) && s != 2) ? REP_BAD : REP_OK};
		return {1'b1, (s == 2) ? REP_BAD : REP_OK};
	endfunction : exp_rep

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		hsize  <= HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb

	task automatic send(input int s, input tnmc_msg_t m, output logic [2:0] code);
		int n;
		rx_msg[s]   <= m;
		rx_valid[s] <= 1'b1;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (rep_valid[s] !== 1'b1 && n < 40);
		code = (n < 40) ? {1'b1, rep_code[2*s +: 2]} : 3'h0;
		chk("taken", {31'h0, n < 40}, {31'h0, rx_taken[s]});
		rx_valid[s] <= 1'b0;
		@(posedge hclk);
	endtask : send

	// watches each network start and the slot counter range
	always @(posedge hclk)
	begin
		cyc       <= cyc + 1;
		busy_prev <= net_busy;
		if (net_tx_start === 1'b1)
		begin
			starts     <= starts + 1;
			last_start <= cyc;
			chk("start slot", {25'h0, module_number}, {25'h0, slot_count});
			chk("start on busy", 32'h0, {31'h0, busy_prev});
		end
		chk("slot range", 32'h1, {31'h0, slot_count < (short_q ? WRAP_SHORT : WRAP_LONG)});
	end

	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		conclude();
	end

	initial
	begin
		int          n;
		int          s;
		int          t0;
		logic [31:0] d;
		logic [2:0]  c;
		logic        l;
		tnmc_msg_t   m;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		send(1, good(8'h07), c);
		chk("boot reply", {29'h0, 1'b1, REP_BUSY}, {29'h0, c});
		repeat (8) @(posedge hclk);
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("status run", 32'h0000_1010, d);
		ahb(1'b0, 8'h40, 32'h0, d);
		chk("unmapped", 32'h0, d);
		ahb(1'b1, REG_CTRL, 32'h1, d);
		ahb(1'b0, REG_CTRL, 32'h0, d);
		short_q <= 1'b1;
		chk("ctrl", 32'h1, d);
		// random messages from all three sources
		for (int i = 0; i < 60; i++)
		begin
			rnd = xs(rnd);
			s = rnd[31:30] % 3;
			m = '{fmt_ok: |rnd[1:0], sum_ok: |rnd[3:2], mtype: rnd[7:4],
				size: rnd[8] ? rnd[23:16] : sz[rnd[10:9]], route: 8'hFF};
			case (rnd[12:11])
				2'h0: m.route = {1'b0, module_number};
				2'h1: m.route = DEV_PORT1 + {1'b0, module_number};
				2'h2: m.route = DEV_LIMIT + {3'h0, rnd[28:24]};
				default: m.route = (s == 2) ? {2'h0, rnd[29:24]} : 8'hFF;
			endcase
			host_slow <= rnd[13];
			send(s, m, c);
			chk("reply", {29'h0, exp_rep(s, m)}, {29'h0, c});
			repeat (6) @(posedge hclk);
		end
		// fill the pool with the host side stalled
		repeat (20) @(posedge hclk);
		host_stall <= 1'b1;
		for (int i = 0; i < NUM_BUF; i++)
		begin
			send(0, good(8'h6B), c);
			chk("pool reply", {29'h0, 1'b1, REP_OK}, {29'h0, c});
		end
		chk("host tx", 32'h1, {31'h0, htx_valid[1]});
		chk("host msg", {10'h0, good(8'h6B)}, {10'h0, htx_msg[1]});
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("free none", 32'h0, {27'h0, d[12:8]});
		send(1, good(8'h07), c);
		chk("full reply", {29'h0, 1'b1, REP_BUSY}, {29'h0, c});
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("overflow flag", 32'h1, {31'h0, d[STAT_RXERR]});
		l = net_tx_err_led;
		n = 0;
		while (net_tx_err_led === l && n < 300)
		begin
			@(posedge hclk);
			n++;
		end
		chk("led flash", 32'h1, {31'h0, n < 300});
		ahb(1'b1, REG_STATUS, 32'h1, d);
		host_stall <= 1'b0;
		repeat (150) @(posedge hclk);
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("drained", 32'h0000_1010, d);
		// network sends and round robin blocking
		send(0, good(8'h05), c);
		chk("net reply", {29'h0, 1'b1, REP_OK}, {29'h0, c});
		chk("no early start", 32'h0, starts);
		n = 0;
		while (starts == 0 && n < 2000)
		begin
			@(posedge hclk);
			n++;
		end
		chk("net msg", {10'h0, good(8'h05)}, {10'h0, net_tx_msg});
		t0 = last_start;
		repeat (4) @(posedge hclk);
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("blocked", 32'h1, {31'h0, d[STAT_BLOCKED]});
		send(1, good(8'h06), c);
		n = 0;
		while (starts < 2 && n < 2000)
		begin
			@(posedge hclk);
			n++;
		end
		chk("blocked gap", 32'h1, {31'h0, last_start - t0 >= 30 * 8});
		// every attempt refused by the peer
		repeat (20) @(posedge hclk);
		net_nak <= 1'b1;
		n = starts;
		send(0, good(8'h05), c);
		s = 0;
		while (rep_valid[0] !== 1'b1 && s < 4000)
		begin
			@(posedge hclk);
			s++;
		end
		chk("fail reply", {30'h0, REP_FAIL}, {30'h0, rep_code[1:0]});
		chk("attempts", 32'h4, starts - n);
		net_nak <= 1'b0;
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("tx fail flag", 32'h1, {31'h0, d[STAT_TXFAIL]});
		ahb(1'b1, REG_STATUS, 32'h2, d);
		// line noise restarts the slot timer
		n = 0;
		while (slot_count !== 7'h05 && n < 400)
		begin
			@(posedge hclk);
			n++;
		end
		net_noise <= 1'b1;
		@(posedge hclk);
		net_noise <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("noise restart", 32'h0, {25'h0, slot_count});
		// power loss with one message held
		host_stall <= 1'b1;
		send(0, good(8'h6B), c);
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("one held", 32'hF, {27'h0, d[12:8]});
		chk("driver on", 32'h1, {31'h0, net_drv_en});
		power_loss_warning <= 1'b1;
		repeat (4) @(posedge hclk);
		chk("driver off", 32'h0, {31'h0, net_drv_en});
		chk("host halted", 32'h0, {30'h0, htx_valid});
		ahb(1'b0, REG_STATUS, 32'h0, d);
		chk("halt status", 32'h0000_1030, d & 32'hFFFF_FFFB);
		send(1, good(8'h07), c);
		chk("no answer", 32'h0, {29'h0, c});
		conclude();
	end
endmodule : tnmc_core_bench
